// >>> shared/ast_consts.svh
// Purpose: constants of the serial transmitter
// Assumes: byte-wide register port, word index addressing
// Notes: offsets are register indices on the plain port
`ifndef AST_CONSTS_SVH
`define AST_CONSTS_SVH
`define AST_REG_DATA 3'h0
`define AST_REG_STAT0 3'h1
`define AST_REG_CTL0 3'h2
`define AST_REG_CTL1 3'h3
`define AST_REG_BRH 3'h4
`define AST_REG_BRL 3'h5
`define AST_REG_IRQ 3'h6
`define AST_REG_MASK 3'h7
// Control 0 fields
`define AST_C0_TEN 7
`define AST_C0_PEN 4
`define AST_C0_PODD 3
`define AST_C0_STOP2 1
// Control 1 fields
`define AST_C1_MP 7
`define AST_C1_MPBT 6
// Status 0 fields
`define AST_ST_MARK 3
`define AST_ST_HOLD 2
`define AST_ST_SHIFT 1
`define AST_ST_CTS 0
// Interrupt bits
`define AST_IRQ_HOLD 0
`define AST_IRQ_DONE 1
`define AST_BRL_RST 8'h01
`endif

// >>> shared/ast_pkg.sv
// Purpose: types of the serial transmitter
// Assumes: nothing
// Notes: constants sit in ast_consts.svh
package ast_pkg;
   typedef enum logic [2:0] {
      AST_IDLE, AST_START, AST_DATA, AST_EXTRA, AST_STOP
   } ast_state_e;
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ast_bus_s;
endpackage

// >>> hw/ast_tx.sv
// Purpose: asynchronous serial transmitter with status and interrupt
// Assumes: one clock, synchronous active-high reset
// Notes:
// Function
// - Eight data bits per character, least significant first
// - Optional even or odd parity bit after the data, except in multiprocessor mode
// - One low start bit, then one or two high stop bits
// - Multiprocessor mode adds a ninth address/data marker bit
// - Characters start only while transmit enable is set
// - Status bit 2 reads one while holding register is empty
// - Data write clears holding-empty until byte moves on
// - Status bit 1 low while shifting, high when shifter empty
// - Status bit 0 returns the clear-to-send input level
// - Last marker bit received in multiprocessor mode shown, cleared on data read
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "ast_consts.svh"
module ast_tx
   import ast_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire ast_bus_s bus,
   output logic [7:0] rdata_ff,
   input wire logic cts_pin,
   input wire logic rx_marker_pin,
   input wire logic rx_marker_stb,
   output logic txd_ff,
   output logic irq_ff
);
   logic [7:0] ctl0_ff, ctl1_ff, brh_ff, brl_ff, hold_ff, sh_ff;
   logic [1:0] irq_st_ff, irq_mask_ff;
   logic hold_empty_ff, mark_ff, cts_s1_ff, cts_s2_ff;
   logic mk_s1_ff, mk_s2_ff, stb_s1_ff, stb_s2_ff, stb_s3_ff;
   logic par_ff, stop_cnt_ff, load;
   logic [2:0] bit_ff;
   logic [15:0] baud_ff;
   ast_state_e st_ff;
   wire logic tick = (baud_ff == 16'h0000);
   wire logic idle = (st_ff == AST_IDLE);
   wire logic wr_data = bus.wr && bus.addr == `AST_REG_DATA;
   wire logic mp_on = ctl1_ff[`AST_C1_MP];

   // Two-stage synchronisers for pin inputs
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cts_s1_ff <= 1'b0;
         cts_s2_ff <= 1'b0;
         mk_s1_ff <= 1'b0;
         mk_s2_ff <= 1'b0;
         stb_s1_ff <= 1'b0;
         stb_s2_ff <= 1'b0;
         stb_s3_ff <= 1'b0;
      end else begin
         cts_s1_ff <= cts_pin;
         cts_s2_ff <= cts_s1_ff;
         mk_s1_ff <= rx_marker_pin;
         mk_s2_ff <= mk_s1_ff;
         stb_s1_ff <= rx_marker_stb;
         stb_s2_ff <= stb_s1_ff;
         stb_s3_ff <= stb_s2_ff;
      end
   end

   // Configuration registers written from the port
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctl0_ff <= 8'h00;
         ctl1_ff <= 8'h00;
         brh_ff <= 8'h00;
         brl_ff <= `AST_BRL_RST;
         irq_mask_ff <= 2'h0;
      end else if (bus.wr) begin
         unique case (bus.addr)
            `AST_REG_CTL0: ctl0_ff <= bus.wdata;
            `AST_REG_CTL1: ctl1_ff <= bus.wdata;
            `AST_REG_BRH: brh_ff <= bus.wdata;
            `AST_REG_BRL: brl_ff <= bus.wdata;
            `AST_REG_MASK: irq_mask_ff <= bus.wdata[1:0];
            default: ;
         endcase
      end
   end

   // Holding register; a load in the write cycle cannot happen when empty=1
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hold_ff <= 8'h00;
         hold_empty_ff <= 1'b1;
      end else if (wr_data) begin
         hold_ff <= bus.wdata;
         hold_empty_ff <= 1'b0;
      end else if (load) begin
         hold_empty_ff <= 1'b1;
      end
   end

   // Start a character when idle, enabled and a byte waits
   assign load = idle && !hold_empty_ff && ctl0_ff[`AST_C0_TEN];

   // Baud counter reloads from the divisor each bit period
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         baud_ff <= 16'h0000;
      end else if (load || tick) begin
         baud_ff <= {brh_ff, brl_ff} - 16'h0001;
      end else begin
         baud_ff <= baud_ff - 16'h0001;
      end
   end

   // Character sequencer
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_ff <= AST_IDLE;
         sh_ff <= 8'h00;
         bit_ff <= 3'h0;
         par_ff <= 1'b0;
         stop_cnt_ff <= 1'b0;
         txd_ff <= 1'b1;
      end else begin
         unique case (st_ff)
            AST_IDLE: begin
               txd_ff <= 1'b1;
               if (load) begin
                  sh_ff <= hold_ff;
                  par_ff <= ctl0_ff[`AST_C0_PODD];
                  txd_ff <= 1'b0;
                  st_ff <= AST_START;
               end
            end
            AST_START: if (tick) begin
               txd_ff <= sh_ff[0];
               par_ff <= par_ff ^ sh_ff[0];
               sh_ff <= {1'b0, sh_ff[7:1]};
               bit_ff <= 3'h0;
               st_ff <= AST_DATA;
            end
            AST_DATA: if (tick) begin
               if (bit_ff == 3'h7) begin
                  if (mp_on) begin
                     txd_ff <= ctl1_ff[`AST_C1_MPBT];
                     st_ff <= AST_EXTRA;
                  end else if (ctl0_ff[`AST_C0_PEN]) begin
                     txd_ff <= par_ff;
                     st_ff <= AST_EXTRA;
                  end else begin
                     txd_ff <= 1'b1;
                     stop_cnt_ff <= ctl0_ff[`AST_C0_STOP2];
                     st_ff <= AST_STOP;
                  end
               end else begin
                  txd_ff <= sh_ff[0];
                  par_ff <= par_ff ^ sh_ff[0];
                  sh_ff <= {1'b0, sh_ff[7:1]};
                  bit_ff <= bit_ff + 3'h1;
               end
            end
            AST_EXTRA: if (tick) begin
               txd_ff <= 1'b1;
               stop_cnt_ff <= ctl0_ff[`AST_C0_STOP2];
               st_ff <= AST_STOP;
            end
            AST_STOP: if (tick) begin
               if (stop_cnt_ff) begin
                  stop_cnt_ff <= 1'b0;
               end else begin
                  st_ff <= AST_IDLE;
               end
            end
            default: st_ff <= AST_IDLE;
         endcase
      end
   end

   // Received marker bit; a new marker wins over the clearing read
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mark_ff <= 1'b0;
      end else if (stb_s2_ff && !stb_s3_ff && mp_on) begin
         mark_ff <= mk_s2_ff;
      end else if (bus.rd && bus.addr == `AST_REG_DATA) begin
         mark_ff <= 1'b0;
      end
   end

   // Sticky events: holding empties, character finishes; set beats clear
   wire logic done_ev = (st_ff == AST_STOP) && tick && !stop_cnt_ff;
   wire logic [1:0] ev = {done_ev, load};
   wire logic [1:0] clr = (bus.wr && bus.addr == `AST_REG_IRQ) ?
      bus.wdata[1:0] : 2'h0;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irq_st_ff <= 2'h0;
         irq_ff <= 1'b0;
      end else begin
         irq_st_ff <= (irq_st_ff & ~clr) | ev;
         irq_ff <= |(((irq_st_ff & ~clr) | ev) & irq_mask_ff);
      end
   end

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge clk_sys) begin
      if (rst || !bus.rd) begin
         rdata_ff <= 8'h00;
      end else begin
         unique case (bus.addr)
            `AST_REG_DATA: rdata_ff <= 8'h00;
            `AST_REG_STAT0: rdata_ff <= {4'h0, mark_ff, hold_empty_ff,
               idle, cts_s2_ff};
            `AST_REG_CTL0: rdata_ff <= ctl0_ff;
            `AST_REG_CTL1: rdata_ff <= ctl1_ff;
            `AST_REG_BRH: rdata_ff <= brh_ff;
            `AST_REG_BRL: rdata_ff <= brl_ff;
            `AST_REG_IRQ: rdata_ff <= {6'h00, irq_st_ff};
            `AST_REG_MASK: rdata_ff <= {6'h00, irq_mask_ff};
            default: rdata_ff <= 8'h00;
         endcase
      end
   end

   // Checks
   hold_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
      wr_data |=> !hold_empty_ff)
      else $error("holding flag not cleared by write");
   start_low_a: assert property (@(posedge clk_sys) disable iff (rst)
      load |=> !txd_ff && st_ff == AST_START)
      else $error("start bit not low");
   no_send_a: assert property (@(posedge clk_sys) disable iff (rst)
      !ctl0_ff[`AST_C0_TEN] && idle |=> idle)
      else $error("sent while disabled");
   idle_high_a: assert property (@(posedge clk_sys) disable iff (rst)
      $past(idle) && idle |-> txd_ff)
      else $error("line not high when idle");
   stop_high_a: assert property (@(posedge clk_sys) disable iff (rst)
      st_ff == AST_STOP |-> txd_ff)
      else $error("stop bit not high");
   bit_first_a: assert property (@(posedge clk_sys) disable iff (rst)
      st_ff == AST_START && tick |=> txd_ff == $past(sh_ff[0]))
      else $error("first data bit not lsb");
   cts_read_a: assert property (@(posedge clk_sys) disable iff (rst)
      bus.rd && bus.addr == `AST_REG_STAT0 |=>
      rdata_ff[`AST_ST_CTS] == $past(cts_s2_ff))
      else $error("cts level wrong");
   shift_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
      bus.rd && bus.addr == `AST_REG_STAT0 && !idle |=>
      !rdata_ff[`AST_ST_SHIFT])
      else $error("shifter empty while busy");
   hold_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
      load |=> hold_empty_ff ##0 st_ff != AST_IDLE)
      else $error("holding flag not set on load");
   mark_clr_a: assert property (@(posedge clk_sys) disable iff (rst)
      bus.rd && bus.addr == `AST_REG_DATA && !(stb_s2_ff && !stb_s3_ff)
      |=> !mark_ff)
      else $error("marker not cleared");
   parity_c: cover property (@(posedge clk_sys)
      st_ff == AST_EXTRA && !mp_on);
   multi_c: cover property (@(posedge clk_sys) st_ff == AST_EXTRA && mp_on);
   two_stop_c: cover property (@(posedge clk_sys)
      st_ff == AST_STOP && stop_cnt_ff && tick);
   irq_c: cover property (@(posedge clk_sys) irq_ff);
endmodule

// >>> sim/ast_rx_model.sv
// Purpose: far-end receiver of the serial line
// Assumes: bit period of div clocks, div of 2 or more
// Notes: samples mid-bit, counts frames in nfr
`timescale 1ns/10ps
module ast_rx_model (
   input wire logic clk_sys,
   input wire logic txd,
   input wire logic [15:0] div,
   input wire logic xbit_en,
   input wire logic stop2
);
   logic [7:0] rx_byte;
   logic rx_x;
   logic rx_ok;
   int nfr = 0;
   // One bit period; mid-bit sampling tolerates a cycle of skew
   task automatic bit_wait();
      repeat (div) @(posedge clk_sys);
   endtask
   // Frame receiver
   initial forever begin
      @(negedge txd);
      repeat (div / 2) @(posedge clk_sys);
      rx_ok = !txd;
      for (int i = 0; i < 8; i++) begin
         bit_wait();
         rx_byte[i] = txd;
      end
      rx_x = 1'b1;
      if (xbit_en) begin
         bit_wait();
         rx_x = txd;
      end
      bit_wait();
      rx_ok = rx_ok & txd;
      if (stop2) begin
         bit_wait();
         rx_ok = rx_ok & txd;
      end
      nfr++;
   end
endmodule

// >>> sim/tb.sv
// Purpose: self-checking bench of the serial transmitter
// Assumes: register port answers one cycle after a read strobe
// Notes: random divisor per frame config, random data except FF in frame 0
`timescale 1ns/10ps
`include "ast_consts.svh"
module tb
   import ast_pkg::*;
;
   logic clk_sys;
   logic rst;
   ast_bus_s bus;
   logic [7:0] rdata;
   logic cts;
   logic mk;
   logic mks;
   logic txd;
   logic irq;
   logic [15:0] div;
   logic xen;
   logic stop2;
   logic [31:0] rs;
   logic [7:0] v;
   logic [7:0] d;
   int fails = 0;
   int num_checks = 0;
   int cyc = 0;
   int n0;
   logic [7:0] c0t [6] = '{8'h00, 8'h10, 8'h18, 8'h1A, 8'h02, 8'h00};
   logic [7:0] c1t [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'hC0};
   // Clock
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   ast_tx ast_tx_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus),
      .rdata_ff(rdata), .cts_pin(cts), .rx_marker_pin(mk),
      .rx_marker_stb(mks), .txd_ff(txd), .irq_ff(irq));
   // Line goes straight to the far end, as if routed to its pin
   ast_rx_model ast_rx_model_inst (.clk_sys(clk_sys), .txd(txd),
      .div(div), .xbit_en(xen), .stop2(stop2));
   // Repeatable random source
   function automatic logic [31:0] xs(logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // Extra bit: marker wins over parity, odd flips even parity
   function automatic logic [7:0] exp_x(logic [7:0] b, c0, c1);
      if (c1[7]) return {7'h00, c1[6]};
      if (c0[4]) return {7'h00, c0[3] ^ (^b)};
      return 8'h01;
   endfunction
   task automatic complete_run();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk8(logic [7:0] g, logic [7:0] e);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Strobes last one cycle; next task starts on a fresh edge
   task automatic wr(logic [2:0] a, logic [7:0] w);
      @(posedge clk_sys);
      bus <= '{a, w, 1'b1, 1'b0};
      @(posedge clk_sys);
      bus <= '{a, w, 1'b0, 1'b0};
   endtask
   task automatic rc(logic [2:0] a, logic [7:0] e);
      @(posedge clk_sys);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_sys);
      bus <= '{a, 8'h00, 1'b0, 1'b0};
      #1 chk8(rdata, e);
   endtask
   // Hang guard
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         complete_run();
      end
   end
   // Main sequence
   initial begin
      rst = 1'b1;
      bus = '0;
      cts = 1'b0;
      mk = 1'b0;
      mks = 1'b0;
      div = 16'h0004;
      xen = 1'b0;
      stop2 = 1'b0;
      rs = 32'h67239E4F;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      rc(`AST_REG_STAT0, 8'h06);
      rc(`AST_REG_CTL0, 8'h00);
      rc(`AST_REG_BRL, 8'h01);
      chk8({7'h00, txd}, 8'h01);
      cts <= 1'b1;
      repeat (4) @(posedge clk_sys);
      rc(`AST_REG_STAT0, 8'h07);
      $display("test reset done");
      wr(`AST_REG_BRH, 8'h00);
      for (int k = 0; k < 6; k++) begin
         rs = xs(rs);
         d = (k == 0) ? 8'hFF : rs[7:0];
         div = 16'(3 + rs[10:8]);
         xen = c1t[k][7] | c0t[k][4];
         stop2 = c0t[k][1];
         wr(`AST_REG_MASK, (k == 2) ? 8'h00 : 8'h03);
         wr(`AST_REG_BRL, div[7:0]);
         // Tables only pair parity with multiprocessor mode off
         wr(`AST_REG_CTL1, c1t[k]);
         wr(`AST_REG_CTL0, c0t[k]);
         // Holding register is empty here, so the write is legal
         wr(`AST_REG_DATA, d);
         rc(`AST_REG_STAT0, 8'h03);
         chk8({7'h00, txd}, 8'h01);
         n0 = ast_rx_model_inst.nfr;
         wr(`AST_REG_CTL0, c0t[k] | 8'h80);
         repeat (2) @(posedge clk_sys);
         rc(`AST_REG_STAT0, 8'h05);
         for (int i = 0; i < 400 && ast_rx_model_inst.nfr == n0; i++)
            @(posedge clk_sys);
         // A frame that never arrives must count as a mismatch
         chk8({7'h00, ast_rx_model_inst.nfr != n0}, 8'h01);
         chk8(ast_rx_model_inst.rx_byte, d);
         chk8({7'h00, ast_rx_model_inst.rx_x},
            exp_x(d, c0t[k], c1t[k]));
         chk8({7'h00, ast_rx_model_inst.rx_ok}, 8'h01);
         repeat (div * 2) @(posedge clk_sys);
         rc(`AST_REG_STAT0, 8'h07);
         chk8({7'h00, irq}, (k == 2) ? 8'h00 : 8'h01);
         rc(`AST_REG_IRQ, 8'h03);
         wr(`AST_REG_IRQ, 8'h03);
         repeat (2) @(posedge clk_sys);
         chk8({7'h00, irq}, 8'h00);
         $display("test frame %0d done", k);
      end
      // Marker capture, then cleared by a data read
      wr(`AST_REG_CTL1, 8'h80);
      mk <= 1'b1;
      mks <= 1'b1;
      repeat (5) @(posedge clk_sys);
      mks <= 1'b0;
      repeat (5) @(posedge clk_sys);
      rc(`AST_REG_STAT0, 8'h0F);
      rc(`AST_REG_DATA, 8'h00);
      rc(`AST_REG_STAT0, 8'h07);
      $display("test marker done");
      complete_run();
   end
endmodule
